// ---- shared/wmc_pkg.sv ----
// Constants, enumerations and carrier structs of the wait-mode sequencer.
// Assumes every user runs on the oscillator clock and imports this package.
`default_nettype none

package wmc_pkg;

    // Oscillator periods in one machine cycle, and how they are used.
    localparam int MC_PERIODS = 13;
    localparam int PC_PERIODS = 12;
    // Divide ratio of the timer and watchdog clock.
    localparam int TMR_DIV = 12;
    // Width of the phase counter of either divider.
    localparam int DIV_W = 4;
    // Oscillator clocks counted after a reset request is released.
    localparam int RST_CLKS = 2048;
    localparam int RST_CNT_W = 12;
    localparam logic [RST_CNT_W-1:0] RST_LAST = 12'(RST_CLKS - 1);
    localparam logic [RST_CNT_W-1:0] RST_CNT_INIT = 12'h000;
    // Machine cycles per instruction class.
    localparam logic [2:0] CYC_BIT_BRANCH = 3'h5;
    localparam logic [2:0] CYC_LONG = 3'h4;
    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_INIT = 3'h0;

    // Sequencer states, Gray coded along reset, run, wait.
    typedef enum logic [1:0] {
        WMC_ST_RESET = 2'b00,
        WMC_ST_RUN = 2'b01,
        WMC_ST_WAIT = 2'b11
    } wmc_state_t;

    // Core mode at the moment a wait starts.
    typedef enum logic [1:0] {
        WMC_MODE_NORMAL = 2'b00,
        WMC_MODE_INT = 2'b01,
        WMC_MODE_NMI = 2'b10
    } wmc_mode_t;

    // Opcode kinds that matter to the sequencer.
    typedef enum logic [1:0] {
        WMC_OP_OTHER = 2'b00,
        WMC_OP_WAIT = 2'b01,
        WMC_OP_STOP = 2'b10
    } wmc_op_t;

    // Instruction classes with their own execution length.
    typedef enum logic [2:0] {
        WMC_CLS_BIT_BRANCH = 3'h0,
        WMC_CLS_BRANCH = 3'h1,
        WMC_CLS_BIT_MANIP = 3'h2,
        WMC_CLS_LOAD = 3'h3,
        WMC_CLS_ALU = 3'h4,
        WMC_CLS_COND_BRANCH = 3'h5,
        WMC_CLS_PROG_CTRL = 3'h6
    } wmc_cls_t;

    // Instruction issued by the decoder.
    typedef struct packed {
        logic valid;
        wmc_op_t op;
        wmc_cls_t cls;
    } wmc_dec_t;

    // Enabled interrupt requests as seen by the core.
    typedef struct packed {
        logic req;
        logic nmi;
    } wmc_irq_t;

    // One-cycle wake-up and skip indications.
    typedef struct packed {
        logic svc;
        logic svc_nmi;
        logic resume;
        logic skip;
    } wmc_wake_t;

    // Clock phase indications of the oscillator dividers.
    typedef struct packed {
        logic mc_tick;
        logic pc_adv;
        logic latch_settle;
        logic tmr_tick;
    } wmc_cyc_t;

endpackage

`default_nettype wire

// ---- rtl/wmc_divider.sv ----
// Free-running modulo counter that divides the oscillator clock.
// Assumes a synchronous active-high reset on the same clock.
`default_nettype none

module wmc_divider #(
    parameter int unsigned MOD = 13
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Phase and the tick at phase zero.
    output logic [wmc_pkg::DIV_W-1:0] phase_out,
    output logic tick_out
);
    import wmc_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } wmc_div_st_t;

    wmc_div_st_t st_reg;
    wmc_div_st_t st_next;

    // Wrap at the modulus; the tick marks the first phase of each period.
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt == DIV_W'(MOD - 1)) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    // State register.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign phase_out = st_reg.cnt;
    assign tick_out = st_reg.tick;

endmodule

`default_nettype wire

// ---- rtl/wmc_sequencer.sv ----
// Wait-mode sequencer and machine-cycle timing of a small 8-bit core.
// Assumes clk_in is the oscillator itself and the decoder, interrupt
// logic and watchdog sit on the same clock; only the reset pin is async.
//
// Contract
// - STOP opcode behaves exactly like WAIT.
// - WAIT halts fetch, peripherals keep running.
// - Oscillator and peripheral clock never stop.
// - Enabled timer interrupt can end WAIT.
// - Reset during WAIT runs full reset sequence.
// - Interrupt wake adds no start-up delay.
// - Normal mode: service interrupt, then continue.
// - NMI mode: continue after WAIT, no service.
// - Interrupt mode, normal irq: resume, no service.
// - Interrupt mode, NMI: service NMI, then resume.
// - No enabled source: only reset wakes.
// - WAIT skipped when enabled request pending.
// - Machine cycle is thirteen oscillator periods.
// - Timer clock is oscillator divided by twelve.
// - Instructions take five, four or two cycles.
// - Reset latched, released after 2048 clocks.
`default_nettype none

module wmc_sequencer (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Reset sources.
    input wire logic ext_rst_n_in,
    input wire logic wdg_rst_in,
    // Decoder side.
    input wire wmc_pkg::wmc_dec_t dec_in,
    input wire wmc_pkg::wmc_mode_t core_mode_in,
    output logic instr_ready_out,
    output logic exec_busy_out,
    output logic exec_done_out,
    output logic fetch_enable_out,
    // Interrupt side.
    input wire wmc_pkg::wmc_irq_t irq_in,
    output wmc_pkg::wmc_wake_t wake_out,
    // Reset and clock status.
    output logic core_rst_out,
    output logic wait_mode_out,
    output logic osc_run_out,
    output wmc_pkg::wmc_cyc_t cyc_out
);
    import wmc_pkg::*;

    typedef struct packed {
        wmc_state_t state;
        wmc_mode_t mode_rec;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic [2:0] pin_sync;
        logic pin_low;
        logic [2:0] exec_cnt;
        logic exec_busy;
        logic exec_done;
        wmc_wake_t wake;
    } wmc_st_t;

    wmc_st_t st_reg;
    wmc_st_t st_next;

    logic [DIV_W-1:0] mc_phase;
    logic mc_tick;
    logic tmr_tick;
    logic rst_req;
    logic pending;
    logic ready;
    logic is_wait_op;
    logic wait_go;

    // Machine-cycle length of each instruction class.
    function automatic logic [2:0] cycles_of(input wmc_cls_t cls);
        logic [2:0] n;
        n = CYC_SHORT;
        case (cls)
            WMC_CLS_BIT_BRANCH: n = CYC_BIT_BRANCH;
            WMC_CLS_BRANCH, WMC_CLS_BIT_MANIP,
            WMC_CLS_LOAD, WMC_CLS_ALU: n = CYC_LONG;
            WMC_CLS_COND_BRANCH, WMC_CLS_PROG_CTRL: n = CYC_SHORT;
            default: n = CYC_SHORT;
        endcase
        return n;
    endfunction

    // The machine-cycle divider; it runs in every state, waits included.
    wmc_divider #(
        .MOD(MC_PERIODS)
    ) u_mc_div (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .phase_out(mc_phase),
        .tick_out(mc_tick)
    );

    // The timer and watchdog divider is kept apart from the machine cycle.
    // Only its tick is needed here, so its phase output is left open.
    wmc_divider #(
        .MOD(TMR_DIV)
    ) u_tmr_div (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .phase_out(),
        .tick_out(tmr_tick)
    );

    // Request decoding shared by the next-state logic and the ports.
    always_comb begin
        rst_req = st_reg.pin_low | wdg_rst_in;
        pending = irq_in.req | irq_in.nmi;
        ready = (st_reg.state == WMC_ST_RUN) && !st_reg.exec_busy;
        is_wait_op = (dec_in.op == WMC_OP_WAIT) || (dec_in.op == WMC_OP_STOP);
        wait_go = ready && dec_in.valid && is_wait_op && !pending && !rst_req;
    end

    // Next-state logic of the whole sequencer.
    always_comb begin
        st_next = st_reg;
        st_next.wake = '0;
        st_next.exec_done = 1'b0;

        // The pin passes three flops; a level counts once two stages agree.
        st_next.pin_sync = {st_reg.pin_sync[1:0], ~ext_rst_n_in};
        if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
            st_next.pin_low = st_reg.pin_sync[2];
        end

        // Instruction timing counts machine cycles, not oscillator periods.
        if (st_reg.exec_busy && mc_tick) begin
            if (st_reg.exec_cnt == 3'h1) begin
                st_next.exec_busy = 1'b0;
                st_next.exec_done = 1'b1;
                st_next.exec_cnt = CYC_INIT;
            end else begin
                st_next.exec_cnt = st_reg.exec_cnt - 3'h1;
            end
        end

        case (st_reg.state)
            WMC_ST_RESET: begin
                // A short pulse is enough: the state holds it until the count ends.
                if (rst_req) begin
                    st_next.rst_cnt = RST_CNT_INIT;
                end else if (st_reg.rst_cnt == RST_LAST) begin
                    st_next.state = WMC_ST_RUN;
                    st_next.rst_cnt = RST_CNT_INIT;
                end else begin
                    st_next.rst_cnt = st_reg.rst_cnt + 12'h001;
                end
            end
            WMC_ST_RUN: begin
                if (rst_req) begin
                    st_next.state = WMC_ST_RESET;
                    st_next.rst_cnt = RST_CNT_INIT;
                    st_next.exec_busy = 1'b0;
                    st_next.exec_cnt = CYC_INIT;
                end else if (ready && dec_in.valid) begin
                    if (!is_wait_op) begin
                        st_next.exec_busy = 1'b1;
                        st_next.exec_cnt = cycles_of(dec_in.cls);
                    end else if (pending) begin
                        st_next.wake.skip = 1'b1;
                    end else begin
                        st_next.state = WMC_ST_WAIT;
                        st_next.mode_rec = core_mode_in;
                    end
                end
            end
            WMC_ST_WAIT: begin
                // Without any enabled source nothing but a reset leaves here.
                if (rst_req) begin
                    st_next.state = WMC_ST_RESET;
                    st_next.rst_cnt = RST_CNT_INIT;
                end else if (pending) begin
                    // Clock never stopped, so the core restarts on the next edge.
                    st_next.state = WMC_ST_RUN;
                    st_next.wake.resume = 1'b1;
                    case (st_reg.mode_rec)
                        WMC_MODE_NORMAL: begin
                            st_next.wake.svc = 1'b1;
                            st_next.wake.svc_nmi = irq_in.nmi;
                        end
                        WMC_MODE_NMI: begin
                            st_next.wake.svc = 1'b0;
                        end
                        WMC_MODE_INT: begin
                            st_next.wake.svc = irq_in.nmi;
                            st_next.wake.svc_nmi = irq_in.nmi;
                        end
                        default: begin
                            st_next.wake.svc = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                st_next.state = WMC_ST_RESET;
                st_next.rst_cnt = RST_CNT_INIT;
            end
        endcase
    end

    // State register; a system reset behaves like a fresh reset request.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Fetch stops in the very cycle the wait opcode is taken.
    assign fetch_enable_out = (st_reg.state == WMC_ST_RUN) && !wait_go;
    assign instr_ready_out = ready;
    assign exec_busy_out = st_reg.exec_busy;
    assign exec_done_out = st_reg.exec_done;
    assign wake_out = st_reg.wake;
    assign core_rst_out = (st_reg.state == WMC_ST_RESET);
    assign wait_mode_out = (st_reg.state == WMC_ST_WAIT);
    // There is no stop state, so the oscillator request is constant.
    assign osc_run_out = 1'b1;

    // Divider phases; the last machine-cycle phase settles the latches.
    always_comb begin
        cyc_out.mc_tick = mc_tick;
        cyc_out.pc_adv = (mc_phase < DIV_W'(PC_PERIODS));
        cyc_out.latch_settle = (mc_phase == DIV_W'(PC_PERIODS));
        cyc_out.tmr_tick = tmr_tick;
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // A stop opcode taken with nothing pending lands in the wait state.
    stop_as_wait_a: assert property (
        ready && dec_in.valid && dec_in.op == WMC_OP_STOP && !pending && !rst_req
        |=> wait_mode_out && !fetch_enable_out)
        else $error("stop did not act as wait");

    // While waiting, no fetch and no new instruction is accepted.
    wait_halt_a: assert property (
        wait_mode_out |-> !fetch_enable_out && !instr_ready_out)
        else $error("fetch active during wait");

    // Peripheral clock keeps ticking during wait.
    wait_clock_a: assert property (
        wait_mode_out |-> ##[0:11] cyc_out.tmr_tick)
        else $error("timer clock stalled in wait");

    // An interrupt ends the wait on the next edge with a resume.
    irq_wake_a: assert property (
        wait_mode_out && pending && !rst_req |=> !wait_mode_out && wake_out.resume)
        else $error("interrupt did not end wait");

    // A reset in wait enters the reset state, not the program.
    wait_reset_a: assert property (
        wait_mode_out && rst_req |=> core_rst_out && !wake_out.resume)
        else $error("reset in wait resumed execution");

    // Normal mode wake services the interrupt.
    normal_wake_a: assert property (
        wait_mode_out && !rst_req && pending && st_reg.mode_rec == WMC_MODE_NORMAL
        |=> wake_out.svc)
        else $error("normal mode wake not serviced");

    // NMI mode wake only resumes.
    nmi_wake_a: assert property (
        wait_mode_out && !rst_req && pending && st_reg.mode_rec == WMC_MODE_NMI
        |=> !wake_out.svc && wake_out.resume)
        else $error("nmi mode wake serviced");

    // Interrupt mode: only a non-maskable request is serviced.
    int_wake_a: assert property (
        wait_mode_out && !rst_req && pending && st_reg.mode_rec == WMC_MODE_INT
        |=> wake_out.svc == $past(irq_in.nmi) && wake_out.svc_nmi == wake_out.svc)
        else $error("interrupt mode wake wrong");

    // Pending request makes the wait opcode a no-op.
    wait_skip_a: assert property (
        ready && dec_in.valid && is_wait_op && pending && !rst_req
        |=> wake_out.skip && !wait_mode_out)
        else $error("wait not skipped");

    // Machine cycle and timer tick periods.
    mc_period_a: assert property (
        cyc_out.mc_tick |-> ##13 cyc_out.mc_tick)
        else $error("machine cycle not 13 clocks");
    tmr_period_a: assert property (
        cyc_out.tmr_tick |-> ##12 cyc_out.tmr_tick)
        else $error("timer clock not divide by 12");

    // Reset is left exactly when the release count completes.
    reset_exit_a: assert property (
        core_rst_out && !rst_req && st_reg.rst_cnt == RST_LAST |=> !core_rst_out)
        else $error("reset exit count wrong");

    // A five-cycle instruction finishes within five machine cycles.
    exec_len_a: assert property (
        ready && dec_in.valid && !rst_req && !is_wait_op
        && dec_in.cls == WMC_CLS_BIT_BRANCH |-> ##[53:66] exec_done_out)
        else $error("bit branch length wrong");

endmodule

`default_nettype wire

// ---- verification/wmc_irq_model.sv ----
// Behavioural model of the interrupt sources and reset logic around the sequencer.
// Assumes the bench steers its commands away from the rising clock edge.
`default_nettype none

module wmc_irq_model (
    // Clock.
    input wire logic clk_in,
    // Commands from the bench.
    input wire logic set_req_in,
    input wire logic set_nmi_in,
    input wire logic clr_in,
    input wire logic wdg_in,
    input wire logic pin_low_in,
    // Answers of the sequencer.
    input wire wmc_pkg::wmc_wake_t wake_in,
    // Lines into the sequencer.
    output wmc_pkg::wmc_irq_t irq_out,
    output logic ext_rst_n_out,
    output logic wdg_rst_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import wmc_pkg::*;

    logic [1:0] pend_reg = 2'h0;

    // A source holds its request until it is serviced, as a latched timer flag does.
    always_ff @(posedge clk_in) begin
        if (clr_in) begin
            pend_reg <= 2'h0;
        end else begin
            pend_reg <= pend_reg | {set_req_in, set_nmi_in};
            if (wake_in.svc && wake_in.svc_nmi) begin
                pend_reg[0] <= 1'b0;
            end else if (wake_in.svc) begin
                pend_reg[1] <= 1'b0;
            end
        end
    end

    // The reset pin has a pull-up, so it idles high when nobody pulls it.
    assign irq_out = {pend_reg[1] | set_req_in, pend_reg[0] | set_nmi_in};
    assign ext_rst_n_out = !pin_low_in;
    assign wdg_rst_out = wdg_in;
endmodule

`default_nettype wire

// ---- verification/test_wmc_sequencer.sv ----
// Self-checking bench of the wait-mode sequencer with its interrupt model.
// Assumes the sequencer and the model share one 125 MHz clock.
`default_nettype none

module test_wmc_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import wmc_pkg::*;

    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic set_req = 1'b0, set_nmi = 1'b0, clr = 1'b0, wdg = 1'b0, pin_low = 1'b0;
    wmc_dec_t dec = 6'h00;
    wmc_mode_t core_mode = WMC_MODE_NORMAL;
    wmc_irq_t irq;
    wmc_wake_t wake_out;
    wmc_cyc_t cyc_out;
    logic ext_rst_n, wdg_rst, instr_ready_out, exec_busy_out, exec_done_out;
    logic fetch_enable_out, core_rst_out, wait_mode_out, osc_run_out;
    int bad_count = 0;
    int checks = 0;

    wmc_sequencer u_wmc_sequencer (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ext_rst_n_in(ext_rst_n),
        .wdg_rst_in(wdg_rst), .dec_in(dec), .core_mode_in(core_mode),
        .instr_ready_out(instr_ready_out), .exec_busy_out(exec_busy_out),
        .exec_done_out(exec_done_out), .fetch_enable_out(fetch_enable_out),
        .irq_in(irq), .wake_out(wake_out), .core_rst_out(core_rst_out),
        .wait_mode_out(wait_mode_out), .osc_run_out(osc_run_out), .cyc_out(cyc_out)
    );

    wmc_irq_model u_wmc_irq_model (
        .clk_in(clk_in), .set_req_in(set_req), .set_nmi_in(set_nmi), .clr_in(clr),
        .wdg_in(wdg), .pin_low_in(pin_low), .wake_in(wake_out), .irq_out(irq),
        .ext_rst_n_out(ext_rst_n), .wdg_rst_out(wdg_rst)
    );

    // The oscillator runs at 125 MHz.
    always #4 clk_in = ~clk_in;

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares a value with its expectation and reports a difference at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // A wait that used up its bound ends the run rather than hanging it.
    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            bad_count++;
            end_of_test();
        end
    endtask

    // Machine cycles that each instruction class is expected to take.
    function automatic int cyc_of(input wmc_cls_t c);
        if (c == WMC_CLS_BIT_BRANCH) begin
            return 5;
        end
        return (c == WMC_CLS_COND_BRANCH || c == WMC_CLS_PROG_CTRL) ? 2 : 4;
    endfunction

    // Presents one opcode for a single taken edge.
    task automatic issue(input wmc_op_t op, input wmc_cls_t cls);
        chk(instr_ready_out, 1);
        dec = {1'b1, op, cls};
        @(negedge clk_in);
        dec.valid = 1'b0;
    endtask

    // Counts the cycles spent in the reset state.
    task automatic rst_len(output int n);
        n = 0;
        while (core_rst_out === 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        guard(n, 3000);
    endtask

    task automatic test_reset;
        int n;
        rst_len(n);
        chk(n, RST_CLKS);
        chk(osc_run_out, 1);
    endtask

    // Measures the spacing of both divider ticks and the phases in between.
    task automatic test_clocks;
        int n, pc, ls;
        n = 0;
        while (cyc_out.mc_tick !== 1'b1 && n < 30) begin
            @(negedge clk_in);
            n++;
        end
        guard(n, 30);
        n = 0;
        pc = 0;
        ls = 0;
        do begin
            @(negedge clk_in);
            n++;
            pc += int'(cyc_out.pc_adv);
            ls += int'(cyc_out.latch_settle);
        end while (cyc_out.mc_tick !== 1'b1 && n < 30);
        chk(n, MC_PERIODS);
        chk(pc, PC_PERIODS);
        chk(ls, 1);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (cyc_out.tmr_tick !== 1'b1 && n < 30);
        guard(n, 30);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (cyc_out.tmr_tick !== 1'b1 && n < 30);
        chk(n, TMR_DIV);
    endtask

    // Every class back to back; the first machine cycle may be partial.
    task automatic test_instr;
        int n, k;
        wmc_cls_t c;
        for (int i = 0; i < 7; i++) begin
            c = wmc_cls_t'(i);
            k = cyc_of(c);
            issue(WMC_OP_OTHER, c);
            chk(exec_busy_out, 1);
            chk(instr_ready_out, 0);
            n = 0;
            while (exec_done_out !== 1'b1 && n < 100) begin
                @(negedge clk_in);
                n++;
            end
            guard(n, 100);
            chk(n >= (k - 1) * 13 + 1 && n <= k * 13 + 1, 1);
        end
    endtask

    // Enters a wait in one mode and wakes it with one kind of request.
    task automatic wake_case(input wmc_op_t op, input wmc_mode_t m, input logic r,
                             input logic nm, input logic [3:0] exp);
        core_mode = m;
        issue(op, WMC_CLS_ALU);
        chk(wait_mode_out, 1);
        chk(fetch_enable_out, 0);
        repeat (5) @(negedge clk_in);
        chk(wait_mode_out, 1);
        set_req = r;
        set_nmi = nm;
        @(negedge clk_in);
        set_req = 1'b0;
        set_nmi = 1'b0;
        chk(wake_out, exp);
        chk(wait_mode_out, 0);
        chk(fetch_enable_out, 1);
        clr = 1'b1;
        @(negedge clk_in);
        clr = 1'b0;
        chk(wake_out, 4'h0);
    endtask

    task automatic test_wake;
        wake_case(WMC_OP_WAIT, WMC_MODE_NORMAL, 1'b1, 1'b0, 4'hA);
        wake_case(WMC_OP_WAIT, WMC_MODE_NORMAL, 1'b0, 1'b1, 4'hE);
        wake_case(WMC_OP_WAIT, WMC_MODE_NMI, 1'b1, 1'b0, 4'h2);
        wake_case(WMC_OP_WAIT, WMC_MODE_NMI, 1'b0, 1'b1, 4'h2);
        wake_case(WMC_OP_WAIT, WMC_MODE_INT, 1'b1, 1'b0, 4'h2);
        wake_case(WMC_OP_WAIT, WMC_MODE_INT, 1'b0, 1'b1, 4'hE);
        wake_case(WMC_OP_STOP, WMC_MODE_NORMAL, 1'b1, 1'b0, 4'hA);
    endtask

    // A pending request makes both wait opcodes fall through.
    task automatic test_skip;
        core_mode = WMC_MODE_NORMAL;
        for (int i = 1; i < 3; i++) begin
            set_req = 1'b1;
            @(negedge clk_in);
            set_req = 1'b0;
            issue(wmc_op_t'(i), WMC_CLS_ALU);
            chk(wake_out, 4'h1);
            chk(wait_mode_out, 0);
            clr = 1'b1;
            @(negedge clk_in);
            clr = 1'b0;
        end
    endtask

    // A short pin pulse in mid-wait still runs the whole reset count.
    task automatic test_pin;
        int n;
        issue(WMC_OP_WAIT, WMC_CLS_ALU);
        pin_low = 1'b1;
        repeat (6) @(negedge clk_in);
        pin_low = 1'b0;
        chk(core_rst_out, 1);
        chk(wait_mode_out, 0);
        rst_len(n);
        chk(n >= RST_CLKS && n <= RST_CLKS + 5, 1);
    endtask

    // With no request the wait holds while the timer clock keeps running.
    task automatic test_idle_wdg;
        int n, t;
        issue(WMC_OP_WAIT, WMC_CLS_ALU);
        t = 0;
        repeat (24) begin
            @(negedge clk_in);
            t += int'(cyc_out.tmr_tick);
        end
        chk(t, 2);
        chk(wait_mode_out, 1);
        chk(wake_out, 4'h0);
        wdg = 1'b1;
        @(negedge clk_in);
        wdg = 1'b0;
        chk(core_rst_out, 1);
        chk(wait_mode_out, 0);
        rst_len(n);
        chk(n, RST_CLKS);
    endtask

    // Main sequence: reset, then one scenario after the other.
    initial begin
        repeat (10) @(negedge clk_in);
        sys_rst_in = 1'b0;
        test_reset();
        test_clocks();
        test_instr();
        test_wake();
        test_skip();
        test_pin();
        test_idle_wdg();
        end_of_test();
    end
endmodule

`default_nettype wire
